/* File: diag_dma_cfg_pkg.sv */
// constants for the diagnostic and socket dma configuration register bank
package diag_dma_cfg_pkg;

    // ==================================================================
    // configuration offsets (byte addresses)
    localparam logic [7:0]  ID_OFF          = 8'h00;
    localparam logic [7:0]  DIAG_OFF        = 8'h93;
    localparam logic [7:0]  DMA_REQ_OFF     = 8'h94;
    localparam logic [7:0]  DMA_WIN_OFF     = 8'h98;

    // ==================================================================
    // reset values and the diagnostic write mask
    localparam logic [7:0]  DIAG_RESET      = 8'h21;
    localparam logic [31:0] DMA_REQ_RESET   = 32'h0000_0000;
    localparam logic [31:0] DMA_WIN_RESET   = 32'h0000_0000;
    localparam logic [7:0]  DIAG_WR_MASK    = 8'hbf;

    // ==================================================================
    // diagnostic field positions
    localparam int DIAG_ID_MASK_BIT  = 7;
    localparam int DIAG_RSVD_BIT     = 6;
    localparam int DIAG_ROUTE_BIT    = 5;
    localparam int DIAG_RETRY_OFF    = 4;
    localparam int DIAG_RETRY_LONG   = 3;
    localparam int DIAG_CB_DROP_BIT  = 2;
    localparam int DIAG_PCI_DROP_BIT = 1;
    localparam int DIAG_ASYNC_BIT    = 0;

    // ==================================================================
    // socket dma field positions
    localparam int WIN_BASE_LSB      = 4;
    localparam int WIN_BASE_MSB      = 15;
    localparam int WIN_EXT_BIT       = 3;
    localparam int WIN_WIDTH_LSB     = 1;
    localparam int WIN_EN_BIT        = 0;

    // ==================================================================
    // timing counts in pci clocks
    localparam logic [6:0]  RETRY_LIMIT_SHORT = 7'd16;
    localparam logic [6:0]  RETRY_LIMIT_LONG  = 7'd64;
    localparam int          DROP_SHORT_CLKS   = 1024;
    localparam int          DROP_LONG_CLKS    = 32768;

    // ==================================================================
    // encodings
    typedef enum logic [1:0] {
        DREQ_NONE   = 2'b00,
        DREQ_SPKR   = 2'b01,
        DREQ_IOIS16 = 2'b10,
        DREQ_INPACK = 2'b11
    } dreq_pin_t;

    typedef enum logic [1:0] {
        XFER_8BIT  = 2'b00,
        XFER_16BIT = 2'b01,
        XFER_RSV2  = 2'b10,
        XFER_RSV3  = 2'b11
    } xfer_width_t;

endpackage

/* File: drop_timer.sv */
// discard timer for one side's delayed transaction
`timescale 1ns/1ps
module drop_timer #(
    parameter int CNT_W      = 16,
    parameter int SHORT_CLKS = 1024,
    parameter int LONG_CLKS  = 32768
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic short_sel,
    input  wire logic start,
    input  wire logic done,
    output logic      running,
    output logic      expired
);
    logic [CNT_W-1:0] cnt_q;
    logic             run_q;
    logic             exp_q;

    // the length is taken at start so a mid-flight rewrite cannot
    // shorten a timer that is already counting
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            exp_q <= 1'b0;
        end else if (ce) begin
            exp_q <= 1'b0;
            if (done) begin
                run_q <= 1'b0;
            end else if (start && !run_q) begin
                run_q <= 1'b1;
                cnt_q <= short_sel ? CNT_W'(SHORT_CLKS - 1)
                                   : CNT_W'(LONG_CLKS - 1);
            end else if (run_q) begin
                if (cnt_q == '0) begin
                    run_q <= 1'b0;
                    exp_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end

    assign running = run_q;
    assign expired = exp_q;
endmodule

/* File: diag_and_socket_dma_config.sv */
// diagnostic and socket dma configuration registers with their control use
`timescale 1ns/1ps
// What this block does
// (R1) software should only write zeros into the diagnostic register
// (R2) diagnostic register is 8 bits at 93h, resets to 21h
// (R3) bit 7 set makes vendor and device id reads all ones
// (R4) diagnostic bit 6 always reads zero
// (R5) routing bit clear: status interrupt to pci when 803 bit 4 set
// (R6) routing bit set: status interrupt to pci when 805 bits 7-4 zero
// (R7) bit 4 set disables delayed transactions on pci side
// (R8) bit 3 set stretches retry latency limit from 16 to 64 clocks
// (R9) bit 2 picks card side discard timer: 2^10 set, 2^15 clear
// (R10) bit 1 picks pci side discard timer: 2^10 set, 2^15 clear
// (R11) bit 0 set makes status interrupts asynchronous, clear synchronous
// (R12) request select register at 94h, reset zero, bits 31-2 read zero
// (R13) bits 1-0 choose dreq pin: none, spkr, iois16, inpack
// (R14) dma window is 16 bytes inside the lowest 64 kbytes of io space
// (R15) no 32-bit dma, widest card transfer is 16 bits
// (R16) window register at 98h, reset zero, bits 31-16 and 3 read only
// (R17) bits 15-4 hold window base, other address bits fixed zero
// (R18) bits 2-1 give card dma width, 00 eight, 01 sixteen bits
// (R19) bit 0 enables window decode, bit 3 reads zero
// (R20) writes to read-only dma register bits are ignored
module diag_and_socket_dma_config
    import diag_dma_cfg_pkg::*;
#(
    parameter logic [31:0] DEVICE_ID_WORD = 32'h1234_5678, // arbitrary
    parameter int          DROP_SHORT     = diag_dma_cfg_pkg::DROP_SHORT_CLKS,
    parameter int          DROP_LONG      = diag_dma_cfg_pkg::DROP_LONG_CLKS
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // configuration access port
    input  wire logic        cfg_req,
    input  wire logic        cfg_we,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic [31:0]      cfg_rdata,
    output logic             cfg_ack,
    // card status change routing
    input  wire logic        card_status_change,
    input  wire logic        legacy_irq_enable,
    input  wire logic [3:0]  legacy_irq_steer,
    output logic             pci_status_irq,
    // delayed transaction controls
    output logic             deferred_retry_off,
    output logic [6:0]       retry_limit_long,
    input  wire logic        pci_dt_start,
    input  wire logic        pci_dt_done,
    output logic             pci_dt_discard,
    input  wire logic        cb_dt_start,
    input  wire logic        cb_dt_done,
    output logic             cb_dt_discard,
    // socket dma
    output dreq_pin_t        dma_request_pin_select,
    output logic [15:0]      dma_window_base,
    output xfer_width_t      dma_transfer_width,
    output logic             dma_window_decode_enable,
    output logic             dma_card_16bit,
    input  wire logic [31:0] io_addr,
    input  wire logic        io_cycle,
    output logic             dma_window_hit
);
    import diag_dma_cfg_pkg::*;

    // ==================================================================
    // register storage
    logic [7:0]  diag_q;
    logic [1:0]  dreq_q;
    logic [11:0] base_q;
    logic [1:0]  width_q;
    logic        en_q;
    logic [31:0] rdata_q;
    logic        ack_q;
    logic        status_sync_q;

    logic        wr;
    logic        hit_diag;
    logic        hit_req;
    logic        hit_win;
    logic        hit_id;
    logic [7:0]  diag_rd;
    logic [31:0] req_rd;
    logic [31:0] win_rd;
    logic [31:0] rdata_d;

    assign wr       = cfg_req && cfg_we;
    assign hit_diag = cfg_addr[7:2] == DIAG_OFF[7:2];
    assign hit_req  = cfg_addr[7:2] == DMA_REQ_OFF[7:2];
    assign hit_win  = cfg_addr[7:2] == DMA_WIN_OFF[7:2];
    assign hit_id   = cfg_addr[7:2] == ID_OFF[7:2];

    // ==================================================================
    // diagnostic register
    // bit 6 is masked off on every write, so it cannot leak back on a read
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            diag_q <= DIAG_RESET; // R2
        end else if (ce && wr && hit_diag && cfg_be[DIAG_OFF[1:0]]) begin
            diag_q <= cfg_wdata[31:24] & DIAG_WR_MASK; // R2 R4
        end
    end

    // ==================================================================
    // socket dma request select register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dreq_q <= DMA_REQ_RESET[1:0]; // R12
        end else if (ce && wr && hit_req && cfg_be[0]) begin
            dreq_q <= cfg_wdata[1:0]; // R13 R20
        end
    end

    // ==================================================================
    // socket dma window control register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            base_q  <= DMA_WIN_RESET[WIN_BASE_MSB:WIN_BASE_LSB]; // R16
            width_q <= DMA_WIN_RESET[2:1];
            en_q    <= DMA_WIN_RESET[WIN_EN_BIT];
        end else if (ce && wr && hit_win) begin
            if (cfg_be[0]) begin
                base_q[3:0] <= cfg_wdata[7:4]; // R17
                width_q     <= cfg_wdata[2:1]; // R18
                en_q        <= cfg_wdata[WIN_EN_BIT]; // R19
            end
            if (cfg_be[1]) begin
                base_q[11:4] <= cfg_wdata[15:8]; // R17
            end
        end
    end

    // ==================================================================
    // read path
    assign diag_rd = diag_q & DIAG_WR_MASK; // R4
    assign req_rd  = {30'h0000_0000, dreq_q}; // R12
    // bits 31-16 and extended addressing bit 3 are hardwired zero
    assign win_rd  = {16'h0000, base_q, 1'b0, width_q, en_q}; // R16 R19

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_id) begin
            rdata_d = diag_q[DIAG_ID_MASK_BIT] ? 32'hffff_ffff
                                               : DEVICE_ID_WORD; // R3
        end else if (hit_diag) begin
            rdata_d = {diag_rd, 24'h00_0000};
        end else if (hit_req) begin
            rdata_d = req_rd;
        end else if (hit_win) begin
            rdata_d = win_rd;
        end
    end

    // every request seen with ce high gets an answer one clock later; unmapped reads give 0
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
            ack_q   <= 1'b0;
        end else if (ce) begin
            ack_q <= cfg_req;
            if (cfg_req && !cfg_we) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign cfg_rdata = rdata_q;
    assign cfg_ack   = ack_q;

    // ==================================================================
    // card status change routing
    logic status_route;

    assign status_route = diag_q[DIAG_ROUTE_BIT]
                        ? (legacy_irq_steer == 4'h0) // R6
                        : legacy_irq_enable; // R5

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            status_sync_q <= 1'b0;
        end else if (ce) begin
            status_sync_q <= card_status_change;
        end
    end

    // async mode bypasses the flop so the interrupt works with mclk stopped
    assign pci_status_irq = status_route && (diag_q[DIAG_ASYNC_BIT]
                            ? card_status_change : status_sync_q); // R11

    // ==================================================================
    // delayed transaction controls
    assign deferred_retry_off = diag_q[DIAG_RETRY_OFF]; // R7
    assign retry_limit_long   = diag_q[DIAG_RETRY_LONG] ? RETRY_LIMIT_LONG
                                                        : RETRY_LIMIT_SHORT; // R8

    logic pci_run;
    logic cb_run;

    // no pci side delayed transaction is started while they are disabled
    drop_timer #(
        .CNT_W      (16),
        .SHORT_CLKS (DROP_SHORT),
        .LONG_CLKS  (DROP_LONG)
    ) u_pci_drop (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .ce        (ce),
        .short_sel (diag_q[DIAG_PCI_DROP_BIT]), // R10
        .start     (pci_dt_start && !diag_q[DIAG_RETRY_OFF]), // R7
        .done      (pci_dt_done),
        .running   (pci_run),
        .expired   (pci_dt_discard)
    );

    drop_timer #(
        .CNT_W      (16),
        .SHORT_CLKS (DROP_SHORT),
        .LONG_CLKS  (DROP_LONG)
    ) u_cb_drop (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .ce        (ce),
        .short_sel (diag_q[DIAG_CB_DROP_BIT]), // R9
        .start     (cb_dt_start),
        .done      (cb_dt_done),
        .running   (cb_run),
        .expired   (cb_dt_discard)
    );

    // ==================================================================
    // socket dma outputs and window decode
    assign dma_request_pin_select   = dreq_pin_t'(dreq_q); // R13
    assign dma_window_base          = {base_q, 4'h0}; // R17
    assign dma_transfer_width       = xfer_width_t'(width_q); // R18
    assign dma_window_decode_enable = en_q; // R19
    // reserved width codes fall back to 8-bit; nothing goes past 16
    assign dma_card_16bit           = width_q == XFER_16BIT; // R15
    assign dma_window_hit = io_cycle && en_q
                         && io_addr[31:4] == {16'h0000, base_q}; // R14

    // ==================================================================
    // checks
    default clocking cb_chk @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic [15:0] pci_age;
    always_ff @(posedge mclk) begin
        if (!rst_n || !pci_run) begin
            pci_age <= 16'h0000;
        end else if (ce) begin
            pci_age <= pci_age + 16'h0001;
        end
    end

    a_diag_bit6_zero: assert property ( // R4
        cfg_ack && $past(cfg_req && !cfg_we && hit_diag && ce)
        |-> cfg_rdata[30] == 1'b0)
        else $error("diagnostic bit 6 read back as one");
    a_id_mask_read: assert property ( // R3
        ce && cfg_req && !cfg_we && hit_id
        |=> cfg_rdata == ($past(diag_q[7]) ? 32'hffff_ffff : DEVICE_ID_WORD))
        else $error("id read does not follow mask bit");
    a_route_legacy: assert property ( // R5
        !diag_q[DIAG_ROUTE_BIT] && !legacy_irq_enable |-> !pci_status_irq)
        else $error("status interrupt routed with legacy enable clear");
    a_route_steer: assert property ( // R6
        diag_q[DIAG_ROUTE_BIT] && legacy_irq_steer != 4'h0
        |-> !pci_status_irq)
        else $error("status interrupt routed with nonzero steering");
    a_async_passes: assert property ( // R11
        diag_q[DIAG_ASYNC_BIT] && status_route
        |-> pci_status_irq == card_status_change)
        else $error("async status interrupt not passed through");
    a_sync_delay: assert property ( // R11
        ce && !diag_q[DIAG_ASYNC_BIT] && status_route ##1
        !diag_q[DIAG_ASYNC_BIT] && status_route
        |-> pci_status_irq == $past(card_status_change))
        else $error("sync status interrupt not one clock late");
    a_retry_limit: assert property ( // R8
        retry_limit_long == (diag_q[3] ? 7'd64 : 7'd16))
        else $error("retry limit does not follow bit 3");
    a_win_rsvd_zero: assert property ( // R16
        ce && cfg_req && !cfg_we && hit_win
        |=> cfg_rdata[31:16] == 16'h0000 && cfg_rdata[3] == 1'b0)
        else $error("window register reserved bits read nonzero");
    a_req_rsvd_zero: assert property ( // R12
        ce && cfg_req && !cfg_we && hit_req
        |=> cfg_rdata[31:2] == 30'h0000_0000)
        else $error("request select reserved bits read nonzero");
    a_hit_needs_en: assert property ( // R19
        dma_window_hit |-> en_q && io_addr[31:16] == 16'h0000)
        else $error("window decode outside enable or 64k");
    a_pci_drop_len: assert property ( // R10
        pci_dt_discard |-> $past(pci_age) == 16'(DROP_SHORT - 1)
        || $past(pci_age) == 16'(DROP_LONG - 1) || !$past(ce))
        else $error("pci discard fired at a wrong count");
    a_no_dt_when_off: assert property ( // R7
        ce && diag_q[DIAG_RETRY_OFF] && !pci_run |=> !pci_run)
        else $error("pci delayed transaction started while disabled");

    c_id_masked: cover property (
        cfg_ack && $past(hit_id && diag_q[7]));
    c_pci_discard: cover property (pci_dt_discard);
    c_window_hit: cover property (dma_window_hit && width_q == XFER_16BIT);
    c_status_routed: cover property (
        pci_status_irq && !diag_q[DIAG_ASYNC_BIT]);
endmodule

/* File: diag_and_socket_dma_config_tb.sv */
// self-checking bench for the diagnostic and socket dma register bank
`timescale 1ns/1ps
module diag_and_socket_dma_config_tb;
    import diag_dma_cfg_pkg::*;
    // ============================================================
    // signals
    localparam logic [31:0] ID_WORD = 32'hcafe_0001; // arbitrary value
    logic        mclk, rst_n, ce, cfg_req, cfg_we, cfg_ack, leg_en, irq;
    logic        stat_chg;
    logic [7:0]  cfg_addr;
    logic [3:0]  cfg_be, steer;
    logic [31:0] cfg_wdata, cfg_rdata, io_addr;
    logic        io_cycle, pci_start, pci_done, pci_disc;
    logic        cb_start, cb_done, cb_disc, retry_off, dec_en, c16, hit;
    logic [6:0]  retry_lim;
    logic [15:0] win_base;
    dreq_pin_t   pin_sel;
    xfer_width_t xw;
    int          mismatches, cmp_count;

    diag_and_socket_dma_config #(.DEVICE_ID_WORD(ID_WORD),
        .DROP_SHORT(16), .DROP_LONG(64)) diag_and_socket_dma_config_i (
        .mclk(mclk), .rst_n(rst_n), .ce(ce), .cfg_req(cfg_req),
        .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
        .card_status_change(stat_chg), .legacy_irq_enable(leg_en),
        .legacy_irq_steer(steer), .pci_status_irq(irq),
        .deferred_retry_off(retry_off), .retry_limit_long(retry_lim),
        .pci_dt_start(pci_start), .pci_dt_done(pci_done),
        .pci_dt_discard(pci_disc), .cb_dt_start(cb_start),
        .cb_dt_done(cb_done), .cb_dt_discard(cb_disc),
        .dma_request_pin_select(pin_sel), .dma_window_base(win_base),
        .dma_transfer_width(xw), .dma_window_decode_enable(dec_en),
        .dma_card_16bit(c16), .io_addr(io_addr), .io_cycle(io_cycle),
        .dma_window_hit(hit));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ============================================================
    // shared tasks
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    // one access; ack must be high just after the edge that takes the request
    task automatic access(input logic we, input logic [7:0] a,
                          input logic [3:0] be, input logic [31:0] d);
        @(posedge mclk);
        cfg_req   <= 1'b1;
        cfg_we    <= we;
        cfg_addr  <= a;
        cfg_be    <= be;
        cfg_wdata <= d;
        @(posedge mclk);
        cfg_req <= 1'b0;
        #1;
        chk({31'h0, cfg_ack}, 32'h1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        access(1'b0, a, 4'h0, 32'h0);
        chk(cfg_rdata, exp);
    endtask

    task automatic set_diag(input logic [7:0] v);
        access(1'b1, 8'h93, 4'h8, {v, 24'h0});
    endtask

    // n is the expected discard distance in edges, 0 when none may come
    task automatic drop(input logic cb, input int n, input int cancel);
        int k;
        @(posedge mclk);
        if (cb) cb_start <= 1'b1;
        else pci_start <= 1'b1;
        @(posedge mclk);
        cb_start  <= 1'b0;
        pci_start <= 1'b0;
        for (k = 1; k <= 100; k++) begin
            if (k == cancel) begin
                pci_done <= 1'b1;
                cb_done  <= 1'b1;
            end else begin
                pci_done <= 1'b0;
                cb_done  <= 1'b0;
            end
            @(posedge mclk);
            #1;
            if ((cb ? cb_disc : pci_disc) === 1'b1) break;
        end
        chk(k, (n == 0) ? 101 : n);
        if (n != 0 && k > 100) close_out();
    endtask

    task automatic win_hit(input logic [31:0] a, input logic cyc,
                           input logic exp);
        @(posedge mclk);
        io_addr  <= a;
        io_cycle <= cyc;
        #1;
        chk({31'h0, hit}, {31'h0, exp});
    endtask

    // ============================================================
    // scenarios
    task automatic sc_reset;
        rd(8'h90, 32'h2100_0000);
        rd(8'h94, 32'h0);
        rd(8'h98, 32'h0);
        rd(8'h00, ID_WORD);
        chk({25'h0, retry_lim}, 32'd16);
        chk({14'h0, pin_sel, win_base}, 32'h0);
        chk({29'h0, dec_en, retry_off, c16}, 32'h0);
    endtask

    task automatic sc_diag;
        set_diag(8'hff);
        rd(8'h90, 32'hbf00_0000);
        rd(8'h00, 32'hffff_ffff);
        chk({25'h0, retry_lim}, 32'd64);
        chk({31'h0, retry_off}, 32'h1);
        access(1'b1, 8'h90, 4'h7, 32'h0000_0000);
        rd(8'h90, 32'hbf00_0000);
        set_diag(8'h00);
        rd(8'h90, 32'h0);
        rd(8'h00, ID_WORD);
        chk({24'h0, retry_off, retry_lim}, 32'd16);
    endtask

    task automatic sc_dreq;
        for (int c = 0; c < 4; c++) begin
            access(1'b1, 8'h94, 4'hf, 32'hffff_fffc | c);
            rd(8'h94, c);
            chk({30'h0, pin_sel}, c);
        end
        access(1'b1, 8'ha0, 4'hf, 32'hffff_ffff);
        rd(8'ha0, 32'h0);
    endtask

    // a request made while ce is low must be neither taken nor answered
    task automatic sc_freeze;
        @(posedge mclk);
        ce        <= 1'b0;
        cfg_req   <= 1'b1;
        cfg_we    <= 1'b1;
        cfg_addr  <= 8'h94;
        cfg_be    <= 4'hf;
        cfg_wdata <= 32'h0;
        @(posedge mclk);
        ce      <= 1'b1;
        cfg_req <= 1'b0;
        @(posedge mclk);
        #1;
        chk({31'h0, cfg_ack}, 32'h0);
        rd(8'h94, 32'h3);
    endtask

    task automatic sc_win;
        access(1'b1, 8'h98, 4'hf, 32'hffff_a5bb);
        rd(8'h98, 32'h0000_a5b3);
        chk({16'h0, win_base}, 32'ha5b0);
        chk({31'h0, dec_en}, 32'h1);
        for (int c = 0; c < 4; c++) begin
            access(1'b1, 8'h98, 4'h1, 32'h51 | (c << 1));
            chk({30'h0, xw}, c);
            chk({31'h0, c16}, (c == 1));
        end
        win_hit(32'h0000_a55f, 1'b1, 1'b1);
        win_hit(32'h0001_a55f, 1'b1, 1'b0);
        win_hit(32'h0000_a56f, 1'b1, 1'b0);
        win_hit(32'h0000_a550, 1'b0, 1'b0);
        access(1'b1, 8'h98, 4'h1, 32'h0000_0050);
        win_hit(32'h0000_a55f, 1'b1, 1'b0);
    endtask

    task automatic sc_irq;
        set_diag(8'h21);
        @(posedge mclk);
        steer    <= 4'h0;
        leg_en   <= 1'b0;
        stat_chg <= 1'b1;
        #1;
        chk({31'h0, irq}, 32'h1);
        @(posedge mclk);
        steer  <= 4'h1;
        leg_en <= 1'b1;
        #1;
        chk({31'h0, irq}, 32'h0);
        set_diag(8'h00);
        @(posedge mclk);
        stat_chg <= 1'b0;
        @(posedge mclk);
        stat_chg <= 1'b1;
        #1;
        chk({31'h0, irq}, 32'h0);
        @(posedge mclk);
        #1;
        chk({31'h0, irq}, 32'h1);
        @(posedge mclk);
        leg_en <= 1'b0;
        repeat (2) @(posedge mclk);
        stat_chg <= 1'b0;
        #1;
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic sc_timer;
        set_diag(8'h06);
        drop(1'b0, 16, 0);
        drop(1'b1, 16, 0);
        drop(1'b0, 0, 4);
        set_diag(8'h00);
        drop(1'b0, 64, 0);
        drop(1'b1, 64, 0);
        set_diag(8'h10);
        drop(1'b0, 0, 0);
        drop(1'b1, 64, 0);
    endtask

    // ============================================================
    // main sequence
    initial begin
        mismatches = 0;
        cmp_count  = 0;
        rst_n      = 1'b0;
        ce         = 1'b1;
        {cfg_req, cfg_we, stat_chg, leg_en, io_cycle} = 5'h0;
        {pci_start, pci_done, cb_start, cb_done} = 4'h0;
        cfg_addr  = 8'h00;
        cfg_be    = 4'h0;
        cfg_wdata = 32'h0;
        steer     = 4'h0;
        io_addr   = 32'h0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        sc_reset();
        sc_diag();
        sc_dreq();
        sc_freeze();
        sc_win();
        sc_irq();
        sc_timer();
        @(posedge mclk);
        rst_n <= 1'b0;
        @(posedge mclk);
        rst_n <= 1'b1;
        sc_reset();
        close_out();
    end
endmodule
